// ===== common/token_node_pkg.sv
package token_node_pkg;

   // Host write map.
   localparam logic [2:0] A_MASK    = 3'h0;
   localparam logic [2:0] A_CMD     = 3'h1;
   // Host read map.
   localparam logic [2:0] A_STATUS  = 3'h0;
   localparam logic [2:0] A_DIAG    = 3'h1;
   // Shared offsets.
   localparam logic [2:0] A_PTR_HI  = 3'h2;
   localparam logic [2:0] A_PTR_LO  = 3'h3;
   localparam logic [2:0] A_DATA    = 3'h4;
   localparam logic [2:0] A_SUBADR  = 3'h5;
   localparam logic [2:0] A_CONFIG  = 3'h6;
   localparam logic [2:0] A_SUBREG  = 3'h7;

   // Sub-address indices behind offset 7.
   localparam logic [2:0] SUB_PROBE  = 3'h0;
   localparam logic [2:0] SUB_OWN    = 3'h1;
   localparam logic [2:0] SUB_LINK_SETUP_PRIMARY = 3'h2;
   localparam logic [2:0] SUB_NEXT   = 3'h3;
   localparam logic [2:0] SUB_LINK_SETUP_SECONDARY = 3'h4;

   // Status bits.
   localparam int B_RI      = 7;
   localparam int B_POR     = 4;
   localparam int B_RECONFIG_TIMER_FLAG   = 2;
   localparam int B_TMA     = 1;
   localparam int B_TA      = 0;
   // Diagnostic status bits.
   localparam int B_EXCESS_NACK_FLAG  = 3;
   localparam int B_PROBE   = 2;
   localparam int B_NEWNEXT = 1;
   // Configuration and pointer control bits.
   localparam int B_SWRESET = 7;
   localparam int B_TRANSMITTER_ENABLE_BIT    = 5;
   localparam int B_RDDATA  = 7;
   localparam int B_AUTOINC = 6;

   localparam logic [7:0] IRQ_SOURCES = 8'h8F;
   localparam logic [7:0] MASK_RESET  = 8'h00;
   localparam logic [7:0] ID_RESET    = 8'h00;
   localparam logic [7:0] CFG_RESET   = 8'h00;

   // Command codes decoded locally.
   localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h0E;
   localparam logic [7:0] CMD_POR_CLEAR   = 8'h16;

   localparam int RAM_AW = 11;
   localparam int RAM_DW = 8;

endpackage : token_node_pkg

// ===== common/ram_port_if.sv
`timescale 1ns/1ps
interface ram_port_if;
   logic [10:0] addr;
   logic [7:0]  wdata;
   logic        we;
   logic        re;
   logic [7:0]  rdata;

   modport user (output addr, output wdata, output we, output re, input rdata);
   modport mem  (input addr, input wdata, input we, input re, output rdata);
endinterface : ram_port_if

// ===== design/packet_ram.sv
`timescale 1ns/1ps
module packet_ram
   import token_node_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Ports.
   ram_port_if.mem  host,
   ram_port_if.mem  core
);

   logic [RAM_DW-1:0] mem [0:(1 << RAM_AW)-1];

   // A core write to the same byte in the same cycle overrides the host.
   always_ff @(posedge clk) begin
      if (host.we) begin
         mem[host.addr] <= host.wdata;
      end
      if (core.we) begin
         mem[core.addr] <= core.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (host.re) begin
         host.rdata <= mem[host.addr];
      end
      if (core.re) begin
         core.rdata <= mem[core.addr];
      end
   end

endmodule : packet_ram

// ===== design/irq_gate.sv
`timescale 1ns/1ps
module irq_gate
   import token_node_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rstn,
   // Mask write.
   input  wire logic       mask_we,
   input  wire logic [7:0] mask_wdata,
   // Flags laid out as the mask.
   input  wire logic [7:0] flags,
   // Interrupt.
   output logic            irq
);

   logic [7:0] mask;
   logic [7:0] eff_mask;

   assign eff_mask = mask_we ? (mask_wdata & IRQ_SOURCES) : mask;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask <= MASK_RESET;
      end else if (mask_we) begin
         mask <= mask_wdata & IRQ_SOURCES;
      end
   end

   // The mask being written is used at once so that the write edge already shows it.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & eff_mask);
      end
   end

endmodule : irq_gate

// ===== design/token_node_regs.sv
//Contract
// - Mask bits align with their status flags.
// - Only five flags may raise the interrupt.
// - Interrupt is OR of flag AND mask.
// - Masking hides interrupt; unmask brings it back.
// - Clear-flags command clears reconfiguration timer flag.
// - Power-on clear command clears excess-nack flag.
// - Reading successor register clears its flag.
// - Hardware reset zeroes interrupt mask.
// - Data port reaches RAM at pointer.
// - Pointer low write preloads data port once.
// - Sub-address bits select identity registers.
// - Probe number seen sets probe flag.
// - Probe and own numbers reset by hardware only.
// - Zero own number keeps core asleep.
// - Nonzero number wakes; transmit waits transmit-enable.
// - Successor register refreshed by network changes.
// - Each successor update sets its flag.
// - Successor register zeroed by either reset.
// - Status resets to one-zero-zero-one-zero-zero-zero-one.
// - Extended timeouts live in configuration register.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module token_node_regs
   import token_node_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rstn,
   // Host register port.
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   // Interrupt.
   output logic            irq,
   // Events and levels from the protocol core.
   input  wire logic       rx_inhibit_set,
   input  wire logic       rx_inhibit_clear,
   input  wire logic       tx_avail_set,
   input  wire logic       tx_avail_clear,
   input  wire logic       reconfig_timer_flag_event,
   input  wire logic       excess_nack_event,
   input  wire logic       probe_seen,
   input  wire logic       successor_load,
   input  wire logic [7:0] successor_value,
   input  wire logic       tx_ack_level,
   input  wire logic [3:0] diag_levels,
   // Controls to the protocol core.
   output logic            core_awake,
   output logic            tx_join,
   output logic            rx_enable,
   output logic            soft_reset,
   output logic            cmd_strobe,
   output logic [7:0]      cmd_code,
   output logic [7:0]      config_out,
   output logic [7:0]      setup_primary,
   output logic [7:0]      setup_secondary,
   output logic [7:0]      test_control,
   output logic [7:0]      probe_number,
   output logic [7:0]      own_number,
   // Core side of the packet RAM.
   input  wire logic [10:0] core_ram_addr,
   input  wire logic        core_ram_we,
   input  wire logic        core_ram_re,
   input  wire logic [7:0]  core_ram_wdata,
   output logic [7:0]       core_ram_rdata
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic sub_hit(input logic [2:0] a,
                                    input logic [2:0] s,
                                    input logic [2:0] want);
      return (a == A_SUBREG) && (s == want);
   endfunction : sub_hit

   function automatic logic [10:0] step(input logic [10:0] p);
      return p + 11'h001;
   endfunction : step

   ////////////////////////////////////////////////////////////////////////
   // Storage.

   logic [7:0]  node_configuration;
   logic [2:0]  subaddr;
   logic [7:0]  probe_node_number;
   logic [7:0]  own_node_number;
   logic [7:0]  link_setup_primary;
   logic [7:0]  link_setup_secondary;
   logic [7:0]  factory_test_control;
   logic [7:0]  token_successor_number;
   logic [10:0] ptr;
   logic [1:0]  ptr_ctl;
   logic        fetch;

   logic receiver_inhibited_flag;
   logic transmitter_available_flag;
   logic por_flag;
   logic reconfig_timer_flag;
   logic excess_nack_flag;
   logic successor_changed_flag;
   logic probe_flag;

   logic       sw_rst;
   logic       cmd_wr;
   logic       clr_flags;
   logic       por_clr;
   logic       next_read;
   logic       data_wr;
   logic       data_rd;
   logic [7:0] flags;
   logic [7:0] read_value;
   logic [7:0] status_value;
   logic [7:0] diag_value;

   ram_port_if host_port ();
   ram_port_if core_port ();

   ////////////////////////////////////////////////////////////////////////
   // Decode.

   assign sw_rst    = node_configuration[B_SWRESET];
   assign cmd_wr    = wr && (addr == A_CMD);
   assign clr_flags = cmd_wr && (wdata == CMD_CLEAR_FLAGS);
   assign por_clr   = cmd_wr && (wdata == CMD_POR_CLEAR);
   assign next_read = rd && sub_hit(addr, subaddr, SUB_NEXT);
   assign data_wr   = wr && (addr == A_DATA);
   assign data_rd   = rd && (addr == A_DATA);

   ////////////////////////////////////////////////////////////////////////
   // Configuration and sub-address.

   always_ff @(posedge clk) begin
      if (!rstn) begin
         node_configuration <= CFG_RESET;
      end else if (wr && (addr == A_CONFIG)) begin
         node_configuration <= wdata;
      end
   end

   // Both the configuration and the sub-address register write the low sub-address bits.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         subaddr <= 3'h0;
      end else if (wr && (addr == A_SUBADR)) begin
         subaddr <= wdata[2:0];
      end else if (wr && (addr == A_CONFIG)) begin
         subaddr <= {subaddr[2], wdata[1:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sub-addressed registers.

   // Identity numbers survive a software reset.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         probe_node_number <= ID_RESET;
      end else if (wr && sub_hit(addr, subaddr, SUB_PROBE)) begin
         probe_node_number <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         own_node_number <= ID_RESET;
      end else if (wr && sub_hit(addr, subaddr, SUB_OWN)) begin
         own_node_number <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         link_setup_primary   <= 8'h00;
         link_setup_secondary <= 8'h00;
         factory_test_control <= 8'h00;
      end else if (wr) begin
         if (sub_hit(addr, subaddr, SUB_LINK_SETUP_PRIMARY)) begin
            link_setup_primary <= wdata;
         end else if (sub_hit(addr, subaddr, SUB_LINK_SETUP_SECONDARY)) begin
            link_setup_secondary <= wdata;
         end else if (sub_hit(addr, subaddr, SUB_NEXT)) begin
            factory_test_control <= wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || sw_rst) begin
         token_successor_number <= ID_RESET;
      end else if (successor_load) begin
         token_successor_number <= successor_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags. A setting event wins over a clear in the same cycle.

   always_ff @(posedge clk) begin
      if (!rstn || sw_rst) begin
         receiver_inhibited_flag    <= 1'b1;
         transmitter_available_flag <= 1'b1;
         por_flag                   <= 1'b1;
      end else begin
         if (rx_inhibit_set) begin
            receiver_inhibited_flag <= 1'b1;
         end else if (rx_inhibit_clear) begin
            receiver_inhibited_flag <= 1'b0;
         end
         if (tx_avail_set) begin
            transmitter_available_flag <= 1'b1;
         end else if (tx_avail_clear) begin
            transmitter_available_flag <= 1'b0;
         end
         if (por_clr) begin
            por_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || sw_rst) begin
         reconfig_timer_flag <= 1'b0;
      end else if (reconfig_timer_flag_event) begin
         reconfig_timer_flag <= 1'b1;
      end else if (clr_flags) begin
         reconfig_timer_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || sw_rst) begin
         excess_nack_flag <= 1'b0;
      end else if (excess_nack_event) begin
         excess_nack_flag <= 1'b1;
      end else if (por_clr) begin
         excess_nack_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || sw_rst) begin
         successor_changed_flag <= 1'b0;
      end else if (successor_load) begin
         successor_changed_flag <= 1'b1;
      end else if (next_read) begin
         successor_changed_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || sw_rst) begin
         probe_flag <= 1'b0;
      end else if (probe_seen) begin
         probe_flag <= 1'b1;
      end else if (clr_flags) begin
         probe_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt.

   always_comb begin
      flags            = 8'h00;
      flags[B_RI]      = receiver_inhibited_flag;
      flags[B_EXCESS_NACK_FLAG]  = excess_nack_flag;
      flags[B_RECONFIG_TIMER_FLAG]   = reconfig_timer_flag;
      flags[B_NEWNEXT] = successor_changed_flag;
      flags[B_TA]      = transmitter_available_flag;
   end

   // The flags are never altered by the mask, so unmasking shows a pending flag again.
   irq_gate u_irq (
      .clk        (clk),
      .rstn       (rstn),
      .mask_we    (wr && (addr == A_MASK)),
      .mask_wdata (wdata),
      .flags      (flags),
      .irq        (irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // Address pointer and data port.

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ptr     <= 11'h000;
         ptr_ctl <= 2'b00;
      end else if (wr && (addr == A_PTR_HI)) begin
         ptr     <= {wdata[2:0], ptr[7:0]};
         ptr_ctl <= wdata[B_RDDATA:B_AUTOINC];
      end else if (wr && (addr == A_PTR_LO)) begin
         ptr <= {ptr[10:8], wdata};
      end else if ((data_wr || data_rd) && ptr_ctl[0]) begin
         ptr <= step(ptr);
      end
   end

   // One fetch per pointer low write, and one per auto-increment read.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fetch <= 1'b0;
      end else begin
         fetch <= (wr && (addr == A_PTR_LO)) || (data_rd && ptr_ctl[0]);
      end
   end

   assign host_port.addr  = ptr;
   assign host_port.wdata = wdata;
   assign host_port.we    = data_wr;
   assign host_port.re    = fetch;

   assign core_port.addr  = core_ram_addr;
   assign core_port.wdata = core_ram_wdata;
   assign core_port.we    = core_ram_we;
   assign core_port.re    = core_ram_re;
   assign core_ram_rdata  = core_port.rdata;

   packet_ram u_ram (
      .clk  (clk),
      .host (host_port),
      .core (core_port)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read path.

   // Bits 6 and 5 read zero; the extended timeouts are in the configuration register.
   assign status_value = {receiver_inhibited_flag, 2'b00, por_flag, 1'b0,
                          reconfig_timer_flag, tx_ack_level,
                          transmitter_available_flag};

   assign diag_value = {diag_levels, excess_nack_flag, probe_flag,
                        successor_changed_flag, 1'b0};

   always_comb begin
      read_value = 8'h00;
      if (addr == A_STATUS) begin
         read_value = status_value;
      end else if (addr == A_DIAG) begin
         read_value = diag_value;
      end else if (addr == A_PTR_HI) begin
         read_value = {ptr_ctl, 3'b000, ptr[10:8]};
      end else if (addr == A_PTR_LO) begin
         read_value = ptr[7:0];
      end else if (addr == A_DATA) begin
         read_value = host_port.rdata;
      end else if (addr == A_SUBADR) begin
         read_value = {5'b00000, subaddr};
      end else if (addr == A_CONFIG) begin
         read_value = {node_configuration[7:2], subaddr[1:0]};
      end else if (subaddr == SUB_PROBE) begin
         read_value = probe_node_number;
      end else if (subaddr == SUB_OWN) begin
         read_value = own_node_number;
      end else if (subaddr == SUB_LINK_SETUP_PRIMARY) begin
         read_value = link_setup_primary;
      end else if (subaddr == SUB_NEXT) begin
         read_value = token_successor_number;
      end else if (subaddr == SUB_LINK_SETUP_SECONDARY) begin
         read_value = link_setup_secondary;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= read_value;
      end else begin
         rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core controls.

   always_ff @(posedge clk) begin
      if (!rstn) begin
         core_awake <= 1'b0;
         tx_join    <= 1'b0;
         rx_enable  <= 1'b0;
      end else begin
         core_awake <= (own_node_number != ID_RESET);
         tx_join    <= (own_node_number != ID_RESET) &&
                       node_configuration[B_TRANSMITTER_ENABLE_BIT];
         rx_enable  <= (own_node_number != ID_RESET);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmd_strobe <= 1'b0;
         cmd_code   <= 8'h00;
      end else begin
         cmd_strobe <= cmd_wr;
         if (cmd_wr) begin
            cmd_code <= wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         soft_reset      <= 1'b0;
         config_out      <= CFG_RESET;
         setup_primary   <= 8'h00;
         setup_secondary <= 8'h00;
         test_control    <= 8'h00;
         probe_number    <= ID_RESET;
         own_number      <= ID_RESET;
      end else begin
         soft_reset      <= sw_rst;
         config_out      <= {node_configuration[7:2], subaddr[1:0]};
         setup_primary   <= link_setup_primary;
         setup_secondary <= link_setup_secondary;
         test_control    <= factory_test_control;
         probe_number    <= probe_node_number;
         own_number      <= own_node_number;
      end
   end

endmodule : token_node_regs

// ===== sim/token_node_chk.sv
`timescale 1ns/1ps
module token_node_chk
   import token_node_pkg::*;
(
   // Clock and reset.
   input wire logic       clk,
   input wire logic       rstn,
   // Host port.
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       irq,
   // Core side.
   input wire logic       successor_load,
   input wire logic       core_awake,
   input wire logic       rx_enable,
   input wire logic       tx_join,
   input wire logic       cmd_strobe,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] own_number,
   input wire logic [7:0] config_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   logic [7:0] mask_copy;
   wire        mask_wr = wr && addr == A_MASK;
   wire        cmd_wr  = wr && addr == A_CMD;

   // Mirror of the stored mask; only the source positions can hold a one.
   always_ff @(posedge clk) begin
      if (!rstn) mask_copy <= 8'h00;
      else if (mask_wr) mask_copy <= wdata & IRQ_SOURCES;
   end

   // Successor update while its mask bit is set and the host keeps quiet.
   sequence succ_armed_s;
      successor_load && mask_copy[B_NEWNEXT] && !mask_wr ##1 !wr && !rd;
   endsequence

   rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not idle");
   irq_reset_a: assert property ($rose(rstn) |-> !irq ##1 !irq)
      else $error("interrupt after reset");
   mask_gate_a: assert property (mask_wr && (wdata & IRQ_SOURCES) == 8'h00 |=> !irq)
      else $error("irq with empty mask");
   irq_mask_a: assert property (irq |-> mask_copy != 8'h00)
      else $error("irq without mask");
   succ_irq_a: assert property (succ_armed_s |=> irq)
      else $error("no successor irq");
   core_sleep_a: assert property ((own_number == 8'h00) [*2] |-> !core_awake && !tx_join)
      else $error("awake at zero id");
   transmitter_enable_bit_gate_a: assert property (!config_out[B_TRANSMITTER_ENABLE_BIT] [*2] |-> !tx_join)
      else $error("join while disabled");
   rx_follow_a: assert property (rx_enable == core_awake)
      else $error("rx not following wake");
   cmd_pulse_a: assert property (cmd_wr |=> cmd_strobe && cmd_code == $past(wdata))
      else $error("command not forwarded");
   cmd_only_a: assert property (cmd_strobe |-> $past(cmd_wr))
      else $error("stray command strobe");
endmodule : token_node_chk

bind token_node_regs token_node_chk u_chk (
   .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
   .successor_load(successor_load), .core_awake(core_awake), .rx_enable(rx_enable), .tx_join(tx_join),
   .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .own_number(own_number), .config_out(config_out));

// ===== sim/core_model.sv
`timescale 1ns/1ps
module core_model
   import token_node_pkg::*;
(
   // Clock.
   input  wire logic        clk,
   // Sequencer events and successor value.
   output logic [7:0]       ev,
   output logic [7:0]       successor_value,
   // Core RAM port.
   output logic [10:0]      ram_addr,
   output logic             ram_we,
   output logic             ram_re,
   output logic [7:0]       ram_wdata,
   input  wire logic [7:0]  ram_rdata
);
   initial begin
      ev = 8'h00;
      successor_value = 8'h00;
      ram_addr = 11'h000;
      ram_we = 1'b0;
      ram_re = 1'b0;
      ram_wdata = 8'h00;
   end

   task automatic fire(input int idx);
      @(posedge clk);
      ev[idx] <= 1'b1;
      @(posedge clk);
      ev[idx] <= 1'b0;
   endtask : fire

   // A network change refreshes the successor; the value is not held afterwards.
   task automatic new_successor(input logic [7:0] v);
      @(posedge clk);
      successor_value <= v;
      ev[7] <= 1'b1;
      @(posedge clk);
      ev[7] <= 1'b0;
      successor_value <= ~v;
   endtask : new_successor

   task automatic ram_wr(input logic [10:0] a, input logic [7:0] d);
      @(posedge clk);
      ram_addr <= a;
      ram_wdata <= d;
      ram_we <= 1'b1;
      @(posedge clk);
      ram_we <= 1'b0;
      ram_wdata <= ~d;
   endtask : ram_wr

   task automatic ram_rd(input logic [10:0] a, output logic [7:0] d);
      @(posedge clk);
      ram_addr <= a;
      ram_re <= 1'b1;
      @(posedge clk);
      ram_re <= 1'b0;
      #1;
      d = ram_rdata;
   endtask : ram_rd
endmodule : core_model

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench
   import token_node_pkg::*;
;
   logic        clk, rstn, wr, rd, irq, tx_ack, awake, join_tx, c_we, c_re, srst;
   logic [2:0]  addr;
   logic [3:0]  diag;
   logic [7:0]  wdata, rdata, got, cmd, own, probe, ev, succ_v, c_wd, c_rd, s1, cfg;
   logic [10:0] c_addr;
   int          mismatches, samples_checked, cycles;

   token_node_regs u_dut (
      .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .rx_inhibit_set(ev[0]), .rx_inhibit_clear(ev[1]), .tx_avail_set(ev[2]), .tx_avail_clear(ev[3]),
      .reconfig_timer_flag_event(ev[4]), .excess_nack_event(ev[5]), .probe_seen(ev[6]), .successor_load(ev[7]),
      .successor_value(succ_v), .tx_ack_level(tx_ack), .diag_levels(diag), .core_awake(awake),
      .tx_join(join_tx), .rx_enable(), .soft_reset(srst), .cmd_strobe(), .cmd_code(cmd), .config_out(cfg),
      .setup_primary(s1), .setup_secondary(), .test_control(), .probe_number(probe), .own_number(own),
      .core_ram_addr(c_addr), .core_ram_we(c_we), .core_ram_re(c_re), .core_ram_wdata(c_wd),
      .core_ram_rdata(c_rd));

   core_model u_core (.clk(clk), .ev(ev), .successor_value(succ_v), .ram_addr(c_addr), .ram_we(c_we),
      .ram_re(c_re), .ram_wdata(c_wd), .ram_rdata(c_rd));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         mismatches++;
         tally_and_finish;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic settle;
      @(posedge clk);
      #1;
   endtask : settle

   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wreg

   task automatic rreg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rreg

   task automatic sel(input logic [2:0] s);
      wreg(A_SUBADR, {5'h00, s});
   endtask : sel

   task automatic rsub(input logic [2:0] s, input logic [7:0] exp);
      sel(s);
      rreg(A_SUBREG, got);
      check(got, exp);
   endtask : rsub

   task automatic chk_irq(input logic b);
      check({7'h00, irq}, {7'h00, b});
   endtask : chk_irq

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rreg(A_STATUS, got);
      check(got, 8'h91);
      chk_irq(1'b0);
      rsub(SUB_PROBE, ID_RESET);
      rsub(SUB_OWN, ID_RESET);
      rsub(SUB_NEXT, 8'h00);
      check({7'h00, awake}, 8'h00);
   endtask : t_reset

   task automatic t_ids;
      sel(SUB_PROBE);
      wreg(A_SUBREG, 8'h21);
      sel(SUB_OWN);
      wreg(A_SUBREG, 8'h05);
      sel(SUB_LINK_SETUP_PRIMARY);
      wreg(A_SUBREG, 8'h9C);
      sel(SUB_LINK_SETUP_SECONDARY);
      wreg(A_SUBREG, 8'h8F);
      rsub(SUB_PROBE, 8'h21);
      rsub(SUB_OWN, 8'h05);
      rsub(SUB_LINK_SETUP_PRIMARY, 8'h9C);
      rsub(SUB_LINK_SETUP_SECONDARY, 8'h8F);
      rsub(3'h5, 8'h00);
      check(probe, 8'h21);
      check({6'h00, awake, join_tx}, 8'h02);
      wreg(A_CONFIG, 8'h20);
      settle;
      check({6'h00, awake, join_tx}, 8'h03);
      check(s1, 8'h9C);
   endtask : t_ids

   task automatic t_soft;
      u_core.new_successor(8'h42);
      rsub(SUB_NEXT, 8'h42);
      wreg(A_CONFIG, 8'hA0);
      settle;
      check({srst, cfg[6:0]}, 8'hA0);
      wreg(A_CONFIG, 8'h20);
      rsub(SUB_NEXT, 8'h00);
      rsub(SUB_OWN, 8'h05);
      rsub(SUB_PROBE, 8'h21);
      rreg(A_STATUS, got);
      check(got, 8'h91);
   endtask : t_soft

   task automatic t_irq;
      wreg(A_MASK, 8'h01);
      chk_irq(1'b1);
      wreg(A_MASK, 8'h00);
      chk_irq(1'b0);
      wreg(A_MASK, 8'h01);
      chk_irq(1'b1);
      u_core.fire(3);
      u_core.fire(1);
      settle;
      chk_irq(1'b0);
      @(posedge clk);
      tx_ack <= 1'b1;
      diag <= 4'hF;
      u_core.fire(6);
      wreg(A_MASK, 8'h8F);
      chk_irq(1'b0);
      rreg(A_DIAG, got);
      check(got, 8'hF4);
      u_core.fire(0);
      settle;
      chk_irq(1'b1);
      wreg(A_MASK, 8'h0F);
      chk_irq(1'b0);
   endtask : t_irq

   task automatic t_cmd;
      u_core.fire(4);
      settle;
      chk_irq(1'b1);
      wreg(A_CMD, CMD_CLEAR_FLAGS);
      check(cmd, CMD_CLEAR_FLAGS);
      settle;
      chk_irq(1'b0);
      rreg(A_DIAG, got);
      check(got, 8'hF0);
      u_core.fire(5);
      settle;
      chk_irq(1'b1);
      wreg(A_CMD, CMD_POR_CLEAR);
      settle;
      chk_irq(1'b0);
      rreg(A_STATUS, got);
      check(got, 8'h82);
      u_core.new_successor(8'h37);
      settle;
      chk_irq(1'b1);
      rsub(SUB_NEXT, 8'h37);
      settle;
      chk_irq(1'b0);
   endtask : t_cmd

   task automatic t_ram;
      wreg(A_PTR_HI, 8'h41);
      wreg(A_PTR_LO, 8'h10);
      wreg(A_DATA, 8'hA5);
      wreg(A_DATA, 8'h5A);
      u_core.ram_rd(11'h110, got);
      check(got, 8'hA5);
      u_core.ram_rd(11'h111, got);
      check(got, 8'h5A);
      u_core.ram_wr(11'h220, 8'h3C);
      u_core.ram_wr(11'h221, 8'h7E);
      wreg(A_PTR_HI, 8'hC2);
      wreg(A_PTR_LO, 8'h20);
      repeat (2) @(posedge clk);
      rreg(A_DATA, got);
      check(got, 8'h3C);
      repeat (2) @(posedge clk);
      rreg(A_DATA, got);
      check(got, 8'h7E);
   endtask : t_ram

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      tx_ack = 1'b0;
      diag = 4'h0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset;
      t_ids;
      t_soft;
      t_irq;
      t_cmd;
      t_ram;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rsub(SUB_OWN, 8'h00);
      chk_irq(1'b0);
      tally_and_finish;
   end
endmodule : testbench
